// ---- test_spectrometer_usb_command_and_trigger.sv ----
// self-checking bench for the command interpreter and trigger sequencer
`timescale 1ns/100ps
`default_nettype none
module test_spectrometer_usb_command_and_trigger;
   logic sys_clk, reset, highSpeedIn, sessionNew, codeFromNvm, bootDone, bootLoad, outValid, outLast;
   logic outReady, auxReqValid, specReq, auxRespValid, auxRespReady, ep1InValid, ep1InReady;
   logic bufValid, bufReady, ep2InValid, ep2InReady, ep6InValid, ep6InReady, trigIn, integStart;
   logic acquire, strobeEnable, powerUp, hostHung;
   logic [15:0] productId;
   logic [7:0] outByte, bufByte;
   logic [9:0] dataPktSize;
   logic [31:0] intTimeUs, rng;
   usbsp_pkg::usbsp_cmd_t auxReq;
   usbsp_pkg::usbsp_byte_t auxResp, ep1In, specOut;
   usbsp_pkg::usbsp_trig_t trigMode;
   logic [7:0] auxQ[$], datQ[$];
   logic [7:0] codes[10] = '{8'h05, 8'h06, 8'h0B, 8'h0C, 8'h0D, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E};
   int miscompares = 0, checkCount = 0, nStart = 0, nAcq = 0, ns, na;
   usbsp_cmd_trig #(.SPEC_BYTES(13'h0008)) uut (.sys_clk(sys_clk), .reset(reset),
      .highSpeedIn(highSpeedIn), .sessionNew(sessionNew), .codeFromNvm(codeFromNvm),
      .bootDone(bootDone), .bootLoad(bootLoad), .productId(productId), .outByte(outByte),
      .outValid(outValid), .outLast(outLast), .outReady(outReady), .auxReq(auxReq),
      .auxReqValid(auxReqValid), .specReq(specReq), .auxResp(auxResp),
      .auxRespValid(auxRespValid), .auxRespReady(auxRespReady), .ep1In(ep1In),
      .ep1InValid(ep1InValid), .ep1InReady(ep1InReady), .bufByte(bufByte), .bufValid(bufValid),
      .bufReady(bufReady), .specOut(specOut), .ep2InValid(ep2InValid), .ep2InReady(ep2InReady),
      .ep6InValid(ep6InValid), .ep6InReady(ep6InReady), .dataPktSize(dataPktSize),
      .trigIn(trigIn), .integStart(integStart), .acquire(acquire), .trigMode(trigMode),
      .intTimeUs(intTimeUs), .strobeEnable(strobeEnable), .powerUp(powerUp));
   usbsp_host_model host (.sys_clk(sys_clk), .outByte(outByte), .outValid(outValid),
      .outLast(outLast), .outReady(outReady), .ep1InReady(ep1InReady),
      .ep2InReady(ep2InReady), .ep6InReady(ep6InReady), .timedOut(hostHung));
   always #50 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   task automatic cmd(input logic [7:0] c, input logic [31:0] p, input int n);
      host.send_cmd(c, p, n);
      tick(3);
   endtask : cmd
   // one byte, held until taken
   task automatic feed(input logic toBuf);
      int w;
      rng = xs(rng);
      @(negedge sys_clk);
      if (toBuf) begin
         bufByte = rng[7:0];
         bufValid = 1'b1;
      end else begin
         auxResp = '{data: rng[7:0], last: 1'b1};
         auxRespValid = 1'b1;
      end
      datQ.push_back(rng[7:0]);
      w = 0;
      @(posedge sys_clk);
      while (!(toBuf ? bufReady : auxRespReady) && w < 50) begin
         w++;
         @(posedge sys_clk);
      end
      if (w >= 50) begin
         miscompares++;
         report_and_stop();
      end
      @(negedge sys_clk);
      bufValid = 1'b0;
      auxRespValid = 1'b0;
      bufByte = ~bufByte;
      auxResp = ~auxResp;
   endtask : feed
   task automatic trig(input logic [7:0] mode, input logic pulse);
      int w;
      cmd(8'h0A, {24'h00_0000, mode}, 1);
      for (w = 0; w < 120 && mode == 1 && !integStart; w++) tick(1);
      if (w >= 120) miscompares++;
      nStart = 0;
      nAcq = 0;
      trigIn = pulse;
      tick(5);
      trigIn = 1'b0;
      tick(200);
      ns = nStart;
      na = nAcq;
   endtask : trig
   // ----------------------------------------------------------------
   // output watchers: each result takes the oldest expectation
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (integStart) nStart++;
      if (acquire) nAcq++;
      if (auxReqValid || specReq)
         check("command", specReq ? 8'h09 : auxReq.code, auxQ.pop_front());
      if (ep1InValid && ep1InReady) check("ep1", ep1In.data, datQ.pop_front());
      if ((ep6InValid && ep6InReady) || (ep2InValid && ep2InReady))
         check("spectrum", specOut.data, datQ.pop_front());
   end
   always @(posedge hostHung) begin
      miscompares++;
      report_and_stop();
   end
   initial begin
      sys_clk = 1'b0; reset = 1'b1; highSpeedIn = 1'b1; sessionNew = 1'b0; codeFromNvm = 1'b1;
      bootDone = 1'b0; auxResp = '0; auxRespValid = 1'b0; bufByte = 8'h00; bufValid = 1'b0;
      trigIn = 1'b0; rng = 32'h0000_06a8;
      tick(6);
      reset = 1'b0;
      tick(2);
      check("trigMode", trigMode, 32'h0000_0000);
      check("productId", productId, 32'h0000_0A01);
      bootDone = 1'b1;
      tick(1);
      bootDone = 1'b0;
      auxQ.push_back(8'h09);
      cmd(8'h09, 32'h0000_0000, 0);
      check("dataPktSize", dataPktSize, 32'h0000_0200);
      repeat (8) feed(1'b1);
      tick(20);
      $display("test spectrum done");
      cmd(8'h02, 32'h0000_000A, 4);
      check("intTimeUs", intTimeUs, 32'h0000_000A);
      cmd(8'h02, 32'h0000_0009, 4);
      cmd(8'h02, 32'h03E7_FC19, 4);
      check("intTimeUs", intTimeUs, 32'h0000_000A);
      cmd(8'h07, 32'h0000_0003, 1);
      check("trigMode", trigMode, 32'h0000_0000);
      for (int m = 1; m < 5; m++) begin
         cmd(8'h0A, m, 1);
         check("trigMode", trigMode, (m < 4) ? m : 3);
      end
      highSpeedIn = 1'b0;
      cmd(8'h01, 32'h0000_0000, 0);
      check("trigMode", trigMode, 32'h0000_0000);
      check("dataPktSize", dataPktSize, 32'h0000_0040);
      cmd(8'h03, 32'h0000_0100, 2);
      check("strobeEnable", strobeEnable, 32'h0000_0001);
      repeat (8) feed(1'b1);
      foreach (codes[i]) begin
         auxQ.push_back(codes[i]);
         cmd(codes[i], rng, 4);
         feed(1'b0);
         tick(4);
      end
      $display("test decode done");
      trig(8'h01, 1'b0);
      check("swNoTrig", {ns >= 2, 31'(na)}, {1'b1, 31'h0});
      trig(8'h01, 1'b1);
      check("swTrig", na, 32'h0000_0001);
      trig(8'h02, 1'b1);
      check("hwTrig", {ns[15:0], na[15:0]}, 32'h0001_0001);
      trig(8'h03, 1'b1);
      check("syncTrig", {ns[15:0], na[15:0]}, 32'h0001_0001);
      trig(8'h00, 1'b0);
      check("normal", {ns >= 2, na == ns}, 2'b11);
      cmd(8'h04, 32'h0000_0000, 2);
      trig(8'h00, 1'b0);
      check("shutdown", {powerUp, ns[30:0]}, 32'h0);
      $display("test trigger done");
      report_and_stop();
   end
endmodule : test_spectrometer_usb_command_and_trigger
`default_nettype wire

// ---- usbsp_cmd_trig.sv ----
// spectrometer command interpreter, trigger sequencer and spectrum router
`timescale 1ns/100ps
`default_nettype none
`include "usbsp_defines.svh"

// Functional notes
// - normal mode: free-running integration clock, scan every period.
// - software mode: acquire at next period start after trigger seen high.
// - hardware mode: each trigger rising edge starts exactly one integration.
// - sync mode: trigger is the integration clock, period 5 ms to 60 s.
// - command 0x0A selects the trigger mode.
// - commands arrive on OUT endpoint 1; first byte code, rest parameters.
// - spectra leave on IN endpoints 2 and 6, other answers on IN 1.
// - packets: 64 bytes control; data 512 high speed, 64 full speed.
// - decode 0x01..0x06 configuration commands.
// - decode plug-in count, identifiers and detect commands 0x0B..0x0D.
// - decode 0x6A register write and 0x6B register read.
// - decode 0x6C board temperature read.
// - decode 0x6D calibration read and 0x6E calibration write.
// - initialize latches bus speed and sets trigger mode to normal.
// - first spectrum request without initialize runs initialize itself.
// - spectral bytes pass buffer to endpoints untouched.
// - at boot, code and coefficients load from nonvolatile memory.
// - product identifier depends on where the code came from.
// - integration time accepted only within 10 us to 65,535,000 us.
// - software mode treats trigger as active-high level.
module usbsp_cmd_trig #(
   parameter logic [15:0] PID_NVM = 16'h0A01,  // arbitrary value
   parameter logic [15:0] PID_HOST = 16'h0A02, // arbitrary value
   parameter logic [12:0] SPEC_BYTES = 13'h1E00
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic highSpeedIn,
   input wire logic sessionNew,
   input wire logic codeFromNvm,
   input wire logic bootDone,
   output var logic bootLoad,
   output var logic [15:0] productId,
   input wire logic [7:0] outByte,
   input wire logic outValid,
   input wire logic outLast,
   output var logic outReady,
   output var usbsp_pkg::usbsp_cmd_t auxReq,
   output var logic auxReqValid,
   output var logic specReq,
   input wire usbsp_pkg::usbsp_byte_t auxResp,
   input wire logic auxRespValid,
   output var logic auxRespReady,
   output var usbsp_pkg::usbsp_byte_t ep1In,
   output var logic ep1InValid,
   input wire logic ep1InReady,
   input wire logic [7:0] bufByte,
   input wire logic bufValid,
   output var logic bufReady,
   output var usbsp_pkg::usbsp_byte_t specOut,
   output var logic ep2InValid,
   input wire logic ep2InReady,
   output var logic ep6InValid,
   input wire logic ep6InReady,
   output var logic [9:0] dataPktSize,
   input wire logic trigIn,
   output var logic integStart,
   output var logic acquire,
   output var usbsp_pkg::usbsp_trig_t trigMode,
   output var logic [31:0] intTimeUs,
   output var logic strobeEnable,
   output var logic powerUp
);

   usbsp_pkg::usbsp_state_t state_r;
   logic [7:0] code_r;
   logic [31:0] params_r;
   logic [2:0] pIdx_r;
   logic initDone_r;
   logic strapTaken_r;
   logic trigPrev_r;
   logic armed_r;
   logic single_r;
   logic [12:0] specCnt_r;
   logic exec;
   logic known;
   logic isAux;
   logic initNow;
   logic trigRise;
   logic softGo;
   logic periodEnd;
   logic timerRun;
   logic timerRestart;
   logic toEp6;
   logic pktEnd;
   logic specTaken;
   logic [29:0] periodCyc;

   // ----------------------------------------------------------------
   // boot and identity
   // ----------------------------------------------------------------
   // commands are held off until the boot load from memory finishes
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bootLoad <= 1'b1;
      end else if (bootDone) begin
         bootLoad <= 1'b0;
      end
   end

   // the strap is caught by a clocked process after reset release
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         strapTaken_r <= 1'b0;
         productId <= 16'h0000;
      end else if (!strapTaken_r) begin
         strapTaken_r <= 1'b1;
         productId <= codeFromNvm ? PID_NVM : PID_HOST;
      end
   end

   // ----------------------------------------------------------------
   // command intake
   // ----------------------------------------------------------------
   // only the first four parameter bytes are kept; longer payloads are
   // consumed so the endpoint never stalls on them
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_r <= usbsp_pkg::USBSP_ST_IDLE;
         outReady <= 1'b0;
         code_r <= 8'h00;
         params_r <= 32'h0000_0000;
         pIdx_r <= 3'h0;
      end else begin
         case (state_r)
            usbsp_pkg::USBSP_ST_IDLE: begin
               if (bootLoad && bootDone) begin
                  outReady <= 1'b1;
               end
               if (outValid && outReady) begin
                  code_r <= outByte;
                  params_r <= 32'h0000_0000;
                  pIdx_r <= 3'h0;
                  if (outLast) begin
                     state_r <= usbsp_pkg::USBSP_ST_EXEC;
                     outReady <= 1'b0;
                  end else begin
                     state_r <= usbsp_pkg::USBSP_ST_PARAM;
                  end
               end
            end
            usbsp_pkg::USBSP_ST_PARAM: begin
               if (outValid && outReady) begin
                  if (pIdx_r < `USBSP_PARAM_BYTES) begin
                     params_r[{pIdx_r[1:0], 3'b000} +: 8] <= outByte;
                     pIdx_r <= pIdx_r + 3'h1;
                  end
                  if (outLast) begin
                     state_r <= usbsp_pkg::USBSP_ST_EXEC;
                     outReady <= 1'b0;
                  end
               end
            end
            usbsp_pkg::USBSP_ST_EXEC: begin
               state_r <= usbsp_pkg::USBSP_ST_IDLE;
               outReady <= 1'b1;
            end
            default: begin
               state_r <= usbsp_pkg::USBSP_ST_IDLE;
               outReady <= 1'b0;
            end
         endcase
      end
   end

   assign exec = (state_r == usbsp_pkg::USBSP_ST_EXEC);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   always_comb begin
      isAux = 1'b0;
      case (code_r)
         `USBSP_CMD_CFG_QUERY, `USBSP_CMD_CFG_WRITE: isAux = 1'b1;
         `USBSP_CMD_PLUG_COUNT, `USBSP_CMD_PLUG_IDS,
         `USBSP_CMD_PLUG_DETECT: isAux = 1'b1;
         `USBSP_CMD_REG_WRITE, `USBSP_CMD_REG_READ: isAux = 1'b1;
         `USBSP_CMD_TEMP_READ: isAux = 1'b1;
         `USBSP_CMD_IRR_READ, `USBSP_CMD_IRR_WRITE: isAux = 1'b1;
         `USBSP_CMD_TWI_READ, `USBSP_CMD_TWI_WRITE, `USBSP_CMD_SPI_IO,
         `USBSP_CMD_INFO_ALT: isAux = 1'b1;
         default: isAux = 1'b0;
      endcase
   end

   // anything not listed here or above falls through untouched
   assign known = isAux || (code_r == `USBSP_CMD_INIT) || (code_r == `USBSP_CMD_INT_TIME)
      || (code_r == `USBSP_CMD_STROBE) || (code_r == `USBSP_CMD_SHUTDOWN)
      || (code_r == `USBSP_CMD_SPECTRUM) || (code_r == `USBSP_CMD_TRIG_MODE);

   assign initNow = exec && ((code_r == `USBSP_CMD_INIT)
      || ((code_r == `USBSP_CMD_SPECTRUM) && !initDone_r));

   // ----------------------------------------------------------------
   // settings
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         trigMode <= usbsp_pkg::usbsp_trig_t'(`USBSP_TRIG_DEFAULT);
         intTimeUs <= `USBSP_INT_RESET_US;
         strobeEnable <= 1'b0;
         powerUp <= 1'b1;
         dataPktSize <= `USBSP_PKT_DATA_FS;
      end else if (exec && known) begin
         if (initNow) begin
            trigMode <= usbsp_pkg::usbsp_trig_t'(`USBSP_TRIG_DEFAULT);
            dataPktSize <= highSpeedIn ? `USBSP_PKT_DATA_HS : `USBSP_PKT_DATA_FS;
         end
         case (code_r)
            `USBSP_CMD_INT_TIME: begin
               if (params_r >= `USBSP_INT_MIN_US && params_r <= `USBSP_INT_MAX_US) begin
                  intTimeUs <= params_r;
               end
            end
            `USBSP_CMD_STROBE: strobeEnable <= |params_r[15:0];
            `USBSP_CMD_SHUTDOWN: powerUp <= |params_r[15:0];
            `USBSP_CMD_TRIG_MODE: begin
               if (params_r[7:2] == 6'h00) begin
                  trigMode <= usbsp_pkg::usbsp_trig_t'(params_r[1:0]);
               end
            end
            default: ;
         endcase
      end
   end

   // a new session forgets the earlier initialize; initialize wins a tie
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         initDone_r <= 1'b0;
      end else if (initNow) begin
         initDone_r <= 1'b1;
      end else if (sessionNew) begin
         initDone_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // requests to the outside handlers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         auxReq <= '0;
         auxReqValid <= 1'b0;
         specReq <= 1'b0;
      end else begin
         auxReqValid <= exec && isAux;
         specReq <= exec && (code_r == `USBSP_CMD_SPECTRUM);
         if (exec && isAux) begin
            auxReq <= '{code: code_r, params: params_r};
         end
      end
   end

   // ----------------------------------------------------------------
   // query answers to IN endpoint 1
   // ----------------------------------------------------------------
   // one holding register; half rate is ample for short answers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ep1In <= '0;
         ep1InValid <= 1'b0;
         auxRespReady <= 1'b1;
      end else if (auxRespReady && auxRespValid) begin
         ep1In <= auxResp;
         ep1InValid <= 1'b1;
         auxRespReady <= 1'b0;
      end else if (ep1InValid && ep1InReady) begin
         ep1InValid <= 1'b0;
         auxRespReady <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // spectral path
   // ----------------------------------------------------------------
   // high speed sends the first block on endpoint 6, the rest on 2
   assign toEp6 = (dataPktSize == `USBSP_PKT_DATA_HS) && (specCnt_r < `USBSP_EP6_BYTES);
   assign pktEnd = (((specCnt_r + 13'h0001) & 13'(dataPktSize - 10'h001)) == 13'h0000)
      || (specCnt_r == SPEC_BYTES - 13'h0001);
   assign specTaken = (ep2InValid && ep2InReady) || (ep6InValid && ep6InReady);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         specOut <= '0;
         ep2InValid <= 1'b0;
         ep6InValid <= 1'b0;
         bufReady <= 1'b1;
         specCnt_r <= 13'h0000;
      end else if (bufReady && bufValid) begin
         specOut <= '{data: bufByte, last: pktEnd};
         ep6InValid <= toEp6;
         ep2InValid <= !toEp6;
         bufReady <= 1'b0;
         specCnt_r <= (specCnt_r == SPEC_BYTES - 13'h0001) ? 13'h0000
            : specCnt_r + 13'h0001;
      end else if (specTaken) begin
         ep2InValid <= 1'b0;
         ep6InValid <= 1'b0;
         bufReady <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // integration timing
   // ----------------------------------------------------------------
   assign periodCyc = 30'(intTimeUs * 32'(`USBSP_CYC_PER_US));
   assign trigRise = trigIn && !trigPrev_r;
   assign softGo = armed_r || trigIn;
   assign timerRun = powerUp && ((trigMode == usbsp_pkg::USBSP_TRG_NORMAL)
      || (trigMode == usbsp_pkg::USBSP_TRG_SOFT) || single_r);
   // the period is read live, so a change after the edge still applies to this period
   assign timerRestart = (trigMode == usbsp_pkg::USBSP_TRG_HARD) && trigRise;

   usbsp_int_timer #(
      .W(30)
   ) u_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .enable(timerRun),
      .restart(timerRestart),
      .periodCyc(periodCyc),
      .periodEnd(periodEnd)
   );

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         trigPrev_r <= 1'b0;
      end else begin
         trigPrev_r <= trigIn;
      end
   end

   // a trigger seen high during the period arms the next acquisition
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         armed_r <= 1'b0;
      end else begin
         armed_r <= (trigMode == usbsp_pkg::USBSP_TRG_SOFT)
            && (trigIn || (armed_r && !periodEnd));
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         single_r <= 1'b0;
      end else if (timerRestart && powerUp) begin
         single_r <= 1'b1;
      end else if (periodEnd || trigMode != usbsp_pkg::USBSP_TRG_HARD) begin
         single_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         integStart <= 1'b0;
         acquire <= 1'b0;
      end else begin
         case (trigMode)
            usbsp_pkg::USBSP_TRG_NORMAL: begin
               integStart <= powerUp && periodEnd;
               acquire <= powerUp && periodEnd;
            end
            usbsp_pkg::USBSP_TRG_SOFT: begin
               integStart <= powerUp && periodEnd;
               acquire <= powerUp && periodEnd && softGo;
            end
            usbsp_pkg::USBSP_TRG_HARD: begin
               integStart <= powerUp && trigRise;
               acquire <= powerUp && single_r && periodEnd;
            end
            default: begin
               integStart <= powerUp && trigRise;
               acquire <= powerUp && trigRise;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence modeCmdSeq;
      exec && code_r == `USBSP_CMD_TRIG_MODE && params_r[7:2] == 6'h00;
   endsequence

   sequence hardArmSeq;
      trigMode == usbsp_pkg::USBSP_TRG_HARD && trigRise && powerUp;
   endsequence

   mode_select_a: assert property (modeCmdSeq |=> trigMode == $past(params_r[1:0]))
      else $error("trigger mode command not applied");
   init_mode_a: assert property (initNow |=> trigMode == usbsp_pkg::USBSP_TRG_NORMAL)
      else $error("initialize did not restore normal mode");
   auto_init_a: assert property (exec && code_r == `USBSP_CMD_SPECTRUM && !initDone_r
      |=> initDone_r && trigMode == usbsp_pkg::USBSP_TRG_NORMAL)
      else $error("spectrum request skipped implicit initialize");
   int_range_a: assert property (exec && code_r == `USBSP_CMD_INT_TIME
      && (params_r < `USBSP_INT_MIN_US || params_r > `USBSP_INT_MAX_US)
      |=> $stable(intTimeUs))
      else $error("out of range integration time accepted");
   unknown_cmd_a: assert property (exec && !known
      |=> $stable(trigMode) && $stable(intTimeUs) && $stable(powerUp))
      else $error("unknown command changed a setting");
   normal_scan_a: assert property (trigMode == usbsp_pkg::USBSP_TRG_NORMAL
      && powerUp && periodEnd |=> acquire && integStart)
      else $error("normal mode missed a scan");
   soft_wait_a: assert property (trigMode == usbsp_pkg::USBSP_TRG_SOFT && !softGo
      |=> !acquire)
      else $error("software mode acquired without trigger");
   hard_once_a: assert property (hardArmSeq |=> integStart && single_r && !acquire)
      else $error("hardware edge did not start one integration");
   sync_clock_a: assert property (trigMode == usbsp_pkg::USBSP_TRG_SYNC && powerUp
      && trigRise |=> integStart && acquire)
      else $error("sync edge did not clock integration");
   ep_route_a: assert property (ep6InValid |-> dataPktSize == `USBSP_PKT_DATA_HS)
      else $error("endpoint 6 used at full speed");

endmodule : usbsp_cmd_trig
`default_nettype wire

// ---- usbsp_defines.svh ----
// constants for the spectrometer command interpreter and trigger sequencer
`ifndef USBSP_DEFINES_SVH
`define USBSP_DEFINES_SVH

// ----------------------------------------------------------------
// command codes taken from the first byte on the command endpoint
// ----------------------------------------------------------------
`define USBSP_CMD_INIT 8'h01
`define USBSP_CMD_INT_TIME 8'h02
`define USBSP_CMD_STROBE 8'h03
`define USBSP_CMD_SHUTDOWN 8'h04
`define USBSP_CMD_CFG_QUERY 8'h05
`define USBSP_CMD_CFG_WRITE 8'h06
`define USBSP_CMD_SPECTRUM 8'h09
`define USBSP_CMD_TRIG_MODE 8'h0A
`define USBSP_CMD_PLUG_COUNT 8'h0B
`define USBSP_CMD_PLUG_IDS 8'h0C
`define USBSP_CMD_PLUG_DETECT 8'h0D
`define USBSP_CMD_TWI_READ 8'h60
`define USBSP_CMD_TWI_WRITE 8'h61
`define USBSP_CMD_SPI_IO 8'h62
`define USBSP_CMD_REG_WRITE 8'h6A
`define USBSP_CMD_REG_READ 8'h6B
`define USBSP_CMD_TEMP_READ 8'h6C
`define USBSP_CMD_IRR_READ 8'h6D
`define USBSP_CMD_IRR_WRITE 8'h6E
`define USBSP_CMD_INFO_ALT 8'hFE

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define USBSP_TRIG_DEFAULT 2'h0
`define USBSP_INT_MIN_US 32'h0000_000A
`define USBSP_INT_MAX_US 32'h03E7_FC18
`define USBSP_INT_RESET_US 32'h0000_2710
`define USBSP_PARAM_BYTES 3'h4

// ----------------------------------------------------------------
// endpoint packet sizes in bytes
// ----------------------------------------------------------------
`define USBSP_PKT_CTRL 10'h040
`define USBSP_PKT_DATA_HS 10'h200
`define USBSP_PKT_DATA_FS 10'h040
`define USBSP_EP6_BYTES 13'h0800

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define USBSP_CLK_PERIOD_NS 100
`define USBSP_NS_PER_US 1000
`define USBSP_CYC_PER_US (`USBSP_NS_PER_US / `USBSP_CLK_PERIOD_NS)

`endif

// ---- usbsp_host_model.sv ----
// host-side model: sends commands on the command endpoint, sinks the IN endpoints
`timescale 1ns/100ps
`default_nettype none
module usbsp_host_model (
   input wire logic sys_clk,
   output var logic [7:0] outByte,
   output var logic outValid,
   output var logic outLast,
   input wire logic outReady,
   output wire logic ep1InReady,
   output wire logic ep2InReady,
   output wire logic ep6InReady,
   output var logic timedOut
);
   logic [1:0] slowCnt = 2'h0;
   initial begin
      outByte = 8'h00;
      outValid = 1'b0;
      outLast = 1'b0;
      timedOut = 1'b0;
   end
   // sinks mix prompt and slow acceptance so stalls are exercised
   always @(negedge sys_clk) slowCnt <= slowCnt + 2'h1;
   assign ep1InReady = slowCnt[0];
   assign ep2InReady = slowCnt[1];
   assign ep6InReady = (slowCnt != 2'h3);
   // code byte first, then n parameter bytes, little endian
   task automatic send_cmd(input logic [7:0] code, input logic [31:0] prm, input int n);
      logic [39:0] all;
      int w;
      all = {prm, code};
      for (int k = 0; k <= n; k++) begin
         @(negedge sys_clk);
         outByte = all[8*k +: 8];
         outValid = 1'b1;
         outLast = (k == n);
         w = 0;
         @(posedge sys_clk);
         while (!outReady && w < 50) begin
            w++;
            @(posedge sys_clk);
         end
         if (w >= 50) timedOut = 1'b1;
      end
      @(negedge sys_clk);
      outValid = 1'b0;
      outLast = 1'b0;
      // released line shows the inverse
      outByte = ~outByte;
   endtask : send_cmd
endmodule : usbsp_host_model
`default_nettype wire

// ---- usbsp_int_timer.sv ----
// integration period timer: pulses once at the end of each period
`timescale 1ns/100ps
`default_nettype none
module usbsp_int_timer #(
   parameter int W = 30
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic restart,
   input wire logic [W-1:0] periodCyc,
   output var logic periodEnd
);

   logic [W-1:0] count_r;

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   // the live period is compared each cycle, so a new integration time
   // takes effect on the running period rather than the next one
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count_r <= '0;
         periodEnd <= 1'b0;
      end else if (restart || !enable) begin
         count_r <= '0;
         periodEnd <= 1'b0;
      end else if (count_r >= periodCyc - W'(1)) begin
         count_r <= '0;
         periodEnd <= 1'b1;
      end else begin
         count_r <= count_r + W'(1);
         periodEnd <= 1'b0;
      end
   end

endmodule : usbsp_int_timer
`default_nettype wire

// ---- usbsp_pkg.sv ----
// types shared by the spectrometer command interpreter files
package usbsp_pkg;

   typedef enum logic [1:0] {
      USBSP_TRG_NORMAL = 2'h0,
      USBSP_TRG_SOFT = 2'h1,
      USBSP_TRG_HARD = 2'h2,
      USBSP_TRG_SYNC = 2'h3
   } usbsp_trig_t;

   typedef enum logic [1:0] {
      USBSP_ST_IDLE = 2'b00,
      USBSP_ST_PARAM = 2'b01,
      USBSP_ST_EXEC = 2'b11
   } usbsp_state_t;

   typedef struct packed {
      logic [7:0] code;
      logic [31:0] params;
   } usbsp_cmd_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } usbsp_byte_t;

endpackage : usbsp_pkg
